// [src/dsm_defines.svh]
// Behaviour
// [R1] On mode change the previous mode stays active for its settable off-delay.
// [R2] Tolerance of 0 to 20 percent widens the maximum speed threshold.
// [R3] On a violation the speed output stays on for up to 750 ms.
// [R4] Safe stop with no sensors switches off standstill and speed outputs.
// [R5] Fan option treats thresholds as minimum speeds; undershoot switches speed off.
// [R6] Thresholds are encoder frequencies held between 50 Hz and 300 kHz.
// [R7] Normal operation violates when frequency exceeds maximum plus tolerance.
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH
`define DSM_CLK_NS 8
`define DSM_MS_NS 1000000
`define DSM_MS_CYC (`DSM_MS_NS / `DSM_CLK_NS)
`define DSM_GATE_MS 100
`define DSM_OFF_CTRL 8'h00
`define DSM_OFF_MAX_AUTO 8'h04
`define DSM_OFF_MAX_SPEC 8'h08
`define DSM_OFF_MAX_AGREE 8'h0c
`define DSM_OFF_STAND 8'h10
`define DSM_OFF_TOL 8'h14
`define DSM_OFF_SOFF 8'h18
`define DSM_OFF_ODL_AUTO 8'h1c
`define DSM_OFF_ODL_SPEC 8'h20
`define DSM_OFF_ODL_AGREE 8'h24
`define DSM_OFF_STATUS 8'h28
`define DSM_OFF_FREQ 8'h2c
`define DSM_FREQ_MIN_HZ 19'h00032
`define DSM_FREQ_MAX_HZ 19'h493e0
`define DSM_TOL_MAX_PCT 5'h14
`define DSM_SOFF_MAX_MS 10'h2ee
`define DSM_ODL_MIN_MS 13'h001e
`define DSM_ODL_AUTO_MAX_MS 13'h1388
`define DSM_ODL_SPEC_MAX_MS 13'h0bb8
`define DSM_ODL_AGREE_MAX_MS 13'h03e8
`define DSM_RST_MAX_HZ 19'h003e8
`define DSM_RST_STAND_HZ 19'h00032
`define DSM_RST_ODL_MS 13'h001e
`endif

// [src/dsm_pkg.sv]
package dsm_pkg;
   typedef enum logic [1:0] {
      DSM_AUTO = 2'h0,
      DSM_SPECIAL = 2'h1,
      DSM_AGREE = 2'h2
   } dsm_mode_t;
   typedef struct packed {
      logic fan;
      logic safe_stop;
      dsm_mode_t mode;
   } dsm_ctrl_t;
   typedef struct packed {
      logic [1:0] enc_sync;
      logic [1:0] det_sync;
      logic enc_prev;
      logic [16:0] ms_cnt;
      logic ms_tick;
      logic [6:0] gate_ms;
      logic [15:0] edge_cnt;
      logic [19:0] freq;
      dsm_ctrl_t ctrl;
      logic [2:0][18:0] max_hz;
      logic [18:0] stand_hz;
      logic [4:0] tol;
      logic [9:0] soff_ms;
      logic [2:0][12:0] odl_ms;
      dsm_mode_t cur_mode;
      dsm_mode_t old_mode;
      logic [12:0] mode_tmr;
      logic [9:0] soff_tmr;
      logic speed;
      logic standstill;
      logic [2:0] mode_active;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dsm_state_t;
endpackage : dsm_pkg

// [src/dsm_top.sv]
`timescale 1ns/1ns
`include "dsm_defines.svh"
module dsm_top #(
   parameter int MS_CYC = `DSM_MS_CYC,
   parameter int GATE_MS = `DSM_GATE_MS
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic enc_pulse,
   input wire logic enc_detect,
   output logic speed_out,
   output logic standstill_out,
   output logic [2:0] mode_active
);
   dsm_pkg::dsm_state_t st_reg, st_next;
   logic [31:0] act_max, freq_x100, lim_x100, max_x100;
   logic violation, sensors, setup_wr;

   function automatic logic [18:0] clamp_hz(input logic [31:0] v);
      if (v < 32'(`DSM_FREQ_MIN_HZ)) begin
         return `DSM_FREQ_MIN_HZ;
      end else if (v > 32'(`DSM_FREQ_MAX_HZ)) begin
         return `DSM_FREQ_MAX_HZ;
      end
      return v[18:0];
   endfunction : clamp_hz

   function automatic logic [12:0] clamp_odl(input logic [31:0] v, input logic [12:0] hi);
      if (v < 32'(`DSM_ODL_MIN_MS)) begin
         return `DSM_ODL_MIN_MS;
      end else if (v > 32'(hi)) begin
         return hi;
      end
      return v[12:0];
   endfunction : clamp_odl

   always_comb begin
      st_next = st_reg;
      sensors = st_reg.det_sync[1];
      // [R1] previous limit holds
      act_max = {13'h0000, st_reg.max_hz[(st_reg.mode_tmr != 13'h0000) ?
                 st_reg.old_mode : st_reg.cur_mode]};
      freq_x100 = 32'(st_reg.freq) * 32'h00000064;
      max_x100 = act_max * 32'h00000064;
      // [R2] tolerance widens limit
      lim_x100 = act_max * (32'h00000064 + 32'(st_reg.tol));
      // [R5] fan minimum speed
      if (st_reg.ctrl.fan) begin
         violation = freq_x100 < max_x100;
      end else begin
         // [R7] over limit check
         violation = freq_x100 > lim_x100;
      end

      st_next.enc_sync = {st_reg.enc_sync[0], enc_pulse};
      st_next.det_sync = {st_reg.det_sync[0], enc_detect};
      st_next.enc_prev = st_reg.enc_sync[1];
      st_next.ms_tick = 1'b0;
      if (st_reg.ms_cnt == 17'(MS_CYC - 1)) begin
         st_next.ms_cnt = 17'h00000;
         st_next.ms_tick = 1'b1;
      end else begin
         st_next.ms_cnt = st_reg.ms_cnt + 17'h00001;
      end

      // Edges are counted over a gate of whole milliseconds and scaled to Hz.
      if (st_reg.enc_sync[1] && !st_reg.enc_prev && st_reg.edge_cnt != 16'hffff) begin
         st_next.edge_cnt = st_reg.edge_cnt + 16'h0001;
      end
      if (st_reg.ms_tick) begin
         if (st_reg.gate_ms == 7'(GATE_MS - 1)) begin
            st_next.gate_ms = 7'h00;
            // An edge on the closing cycle opens the next gate, so none is lost.
            st_next.edge_cnt = 16'(st_reg.enc_sync[1] && !st_reg.enc_prev);
            st_next.freq = 20'(32'(st_reg.edge_cnt) * 32'(1000 / GATE_MS));
         end else begin
            st_next.gate_ms = st_reg.gate_ms + 7'h01;
         end
      end

      // [R1] mode change off-delay
      if (st_reg.ctrl.mode != st_reg.cur_mode) begin
         st_next.old_mode = st_reg.cur_mode;
         st_next.cur_mode = st_reg.ctrl.mode;
         // The first tick may come at once, so one tick is added to keep the full delay.
         st_next.mode_tmr = st_reg.odl_ms[st_reg.cur_mode] + 13'h0001;
      end else if (st_reg.ms_tick && st_reg.mode_tmr != 13'h0000) begin
         st_next.mode_tmr = st_reg.mode_tmr - 13'h0001;
      end
      st_next.mode_active = 3'(3'h1 << st_next.cur_mode);
      if (st_next.mode_tmr != 13'h0000) begin
         st_next.mode_active = st_next.mode_active | 3'(3'h1 << st_next.old_mode);
      end

      // The first tick after a violation may come at once, so one extra tick is counted.
      // [R3] speed switch-off delay
      if (!violation) begin
         st_next.soff_tmr = 10'h000;
         st_next.speed = 1'b1;
      end else if (st_reg.soff_ms == 10'h000 || st_reg.soff_tmr > st_reg.soff_ms) begin
         st_next.speed = 1'b0;
      end else if (st_reg.ms_tick) begin
         st_next.soff_tmr = st_reg.soff_tmr + 10'h001;
      end
      st_next.standstill = 32'(st_reg.freq) <= 32'(st_reg.stand_hz);
      // [R4] safe stop without sensors
      if (st_reg.ctrl.safe_stop && !sensors) begin
         st_next.speed = 1'b0;
         st_next.standstill = 1'b0;
      end

      // One wait state: pready rises in the second access cycle.
      st_next.pready = psel && penable && !st_reg.pready;
      st_next.pslverr = 1'b0;
      setup_wr = psel && penable && !st_reg.pready && pwrite;
      if (psel && penable && !st_reg.pready) begin
         st_next.prdata = 32'h00000000;
         if (paddr == `DSM_OFF_CTRL) begin
            st_next.prdata = 32'(st_reg.ctrl);
            if (setup_wr) begin
               st_next.ctrl.fan = pwdata[3];
               st_next.ctrl.safe_stop = pwdata[2];
               st_next.ctrl.mode = (pwdata[1:0] == 2'h3) ? dsm_pkg::DSM_AGREE :
                                   dsm_pkg::dsm_mode_t'(pwdata[1:0]);
            end
         end else if (paddr >= `DSM_OFF_MAX_AUTO && paddr <= `DSM_OFF_MAX_AGREE &&
                      paddr[1:0] == 2'h0) begin
            st_next.prdata = 32'(st_reg.max_hz[paddr[3:2] - 2'h1]);
            // [R6] frequency range clamp
            if (setup_wr) begin
               st_next.max_hz[paddr[3:2] - 2'h1] = clamp_hz(pwdata);
            end
         end else if (paddr == `DSM_OFF_STAND) begin
            st_next.prdata = 32'(st_reg.stand_hz);
            if (setup_wr) begin
               st_next.stand_hz = clamp_hz(pwdata);
            end
         end else if (paddr == `DSM_OFF_TOL) begin
            st_next.prdata = 32'(st_reg.tol);
            // [R2] tolerance clamp
            if (setup_wr) begin
               st_next.tol = (pwdata > 32'(`DSM_TOL_MAX_PCT)) ? `DSM_TOL_MAX_PCT : pwdata[4:0];
            end
         end else if (paddr == `DSM_OFF_SOFF) begin
            st_next.prdata = 32'(st_reg.soff_ms);
            // [R3] delay clamp
            if (setup_wr) begin
               st_next.soff_ms = (pwdata > 32'(`DSM_SOFF_MAX_MS)) ? `DSM_SOFF_MAX_MS :
                                 pwdata[9:0];
            end
         end else if (paddr == `DSM_OFF_ODL_AUTO) begin
            st_next.prdata = 32'(st_reg.odl_ms[0]);
            if (setup_wr) begin
               st_next.odl_ms[0] = clamp_odl(pwdata, `DSM_ODL_AUTO_MAX_MS);
            end
         end else if (paddr == `DSM_OFF_ODL_SPEC) begin
            st_next.prdata = 32'(st_reg.odl_ms[1]);
            if (setup_wr) begin
               st_next.odl_ms[1] = clamp_odl(pwdata, `DSM_ODL_SPEC_MAX_MS);
            end
         end else if (paddr == `DSM_OFF_ODL_AGREE) begin
            st_next.prdata = 32'(st_reg.odl_ms[2]);
            if (setup_wr) begin
               st_next.odl_ms[2] = clamp_odl(pwdata, `DSM_ODL_AGREE_MAX_MS);
            end
         end else if (paddr == `DSM_OFF_STATUS) begin
            st_next.prdata = {23'h000000, violation, sensors, st_reg.mode_active,
                              st_reg.cur_mode, st_reg.standstill, st_reg.speed};
         end else if (paddr == `DSM_OFF_FREQ) begin
            st_next.prdata = 32'(st_reg.freq);
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st_reg <= '0;
         st_reg.max_hz <= {3{`DSM_RST_MAX_HZ}};
         st_reg.stand_hz <= `DSM_RST_STAND_HZ;
         st_reg.odl_ms <= {3{`DSM_RST_ODL_MS}};
         st_reg.mode_active <= 3'h1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   assign pready = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign speed_out = st_reg.speed;
   assign standstill_out = st_reg.standstill;
   assign mode_active = st_reg.mode_active;

   mode_hold_a: assert property (@(posedge clock) disable iff (reset) // [R1]
      st_reg.mode_tmr != 13'h0000 |-> st_reg.mode_active[st_reg.old_mode])
      else $error("Previous mode dropped during off-delay.");
   mode_load_a: assert property (@(posedge clock) disable iff (reset) // [R1]
      st_reg.ctrl.mode != st_reg.cur_mode |=> st_reg.mode_tmr >= `DSM_ODL_MIN_MS)
      else $error("Off-delay not loaded on mode change.");
   tol_range_a: assert property (@(posedge clock) disable iff (reset) // [R2]
      st_reg.tol <= `DSM_TOL_MAX_PCT)
      else $error("Tolerance above limit.");
   soff_hold_a: assert property (@(posedge clock) disable iff (reset) // [R3]
      violation && st_reg.soff_tmr < st_reg.soff_ms && speed_out &&
      !(st_reg.ctrl.safe_stop && !sensors) |=> speed_out)
      else $error("Speed output dropped before switch-off delay.");
   safe_stop_a: assert property (@(posedge clock) disable iff (reset) // [R4]
      st_reg.ctrl.safe_stop && !sensors |=> !speed_out && !standstill_out)
      else $error("Safe stop without sensors left an output on.");
   fan_low_a: assert property (@(posedge clock) disable iff (reset) // [R5]
      st_reg.ctrl.fan && st_reg.freq == 20'h00000 |-> violation)
      else $error("Fan undershoot not seen as violation.");
   freq_range_a: assert property (@(posedge clock) disable iff (reset) // [R6]
      st_reg.max_hz[0] >= `DSM_FREQ_MIN_HZ && st_reg.max_hz[0] <= `DSM_FREQ_MAX_HZ &&
      st_reg.max_hz[1] >= `DSM_FREQ_MIN_HZ && st_reg.max_hz[1] <= `DSM_FREQ_MAX_HZ &&
      st_reg.max_hz[2] >= `DSM_FREQ_MIN_HZ && st_reg.max_hz[2] <= `DSM_FREQ_MAX_HZ &&
      st_reg.stand_hz >= `DSM_FREQ_MIN_HZ && st_reg.stand_hz <= `DSM_FREQ_MAX_HZ)
      else $error("Threshold frequency out of range.");
   over_limit_a: assert property (@(posedge clock) disable iff (reset) // [R7]
      !st_reg.ctrl.fan && 32'(st_reg.freq) > 32'h00057e40 |-> violation)
      else $error("Overspeed not detected.");
   violation_c: cover property (@(posedge clock) disable iff (reset) $fell(speed_out));
   mode_change_c: cover property (@(posedge clock) disable iff (reset) $rose(|st_reg.mode_tmr));
   safe_stop_c: cover property (@(posedge clock) disable iff (reset)
      st_reg.ctrl.safe_stop && !sensors);
endmodule : dsm_top

// [test/dsm_enc_model.sv]
`timescale 1ns/1ns
module dsm_enc_model (
   input wire logic clock,
   input wire logic [7:0] half,
   input wire logic present,
   output logic enc_pulse,
   output logic enc_detect
);
   logic [7:0] cnt_reg = 8'h00;
   initial enc_pulse = 1'b0;
   assign enc_detect = present;
   // bounded pulse rate
   // A stopped sensor parks the track low, so no stray edge is counted.
   always @(posedge clock) begin
      if (half == 8'h00) begin
         enc_pulse <= 1'b0;
         cnt_reg <= 8'h00;
      end else if (cnt_reg >= half - 8'h01) begin
         enc_pulse <= ~enc_pulse;
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
endmodule : dsm_enc_model

// [test/drive_speed_monitor_bench.sv]
`timescale 1ns/1ns
module drive_speed_monitor_bench;
   typedef struct packed {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } dsm_row_t;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready, pslverr, enc_pulse, enc_detect, speed_out, standstill_out;
   logic [2:0] mode_active;
   logic [7:0] half = 8'h00;
   logic present = 1'b1;
   logic [31:0] rd;
   logic err;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   dsm_row_t rows [10] = '{
      '{8'h14, 32'h19, 32'h14}, '{8'h14, 32'h14, 32'h14}, '{8'h04, 32'ha, 32'h32},
      '{8'h04, 32'h61a80, 32'h493e0}, '{8'h10, 32'h31, 32'h32}, '{8'h18, 32'h320, 32'h2ee},
      '{8'h1c, 32'h1770, 32'h1388}, '{8'h20, 32'h1770, 32'hbb8},
      '{8'h24, 32'h1770, 32'h3e8}, '{8'h24, 32'ha, 32'h1e}};

   always #4 clock = ~clock;

   dsm_top #(.MS_CYC(10), .GATE_MS(10)) uut (.clock(clock), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .enc_pulse(enc_pulse), .enc_detect(enc_detect),
      .speed_out(speed_out), .standstill_out(standstill_out), .mode_active(mode_active));

   dsm_enc_model sensor (.clock(clock), .half(half), .present(present),
      .enc_pulse(enc_pulse), .enc_detect(enc_detect));

   task automatic final_report();
      $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report

   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : wait_cyc

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Three measuring gates of 100 cycles each let the speed figure settle.
   task automatic settle();
      wait_cyc(300);
   endtask : settle

   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_mismatch++;
         final_report();
      end
   end

   initial begin
      wait_cyc(2);
      reset <= 1'b0;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk("clamped register", rd, rows[i].e);
      end
      apb(1'b1, 8'h30, 32'h5);
      chk("unmapped error", {31'h0, err}, 32'h1);
      @(posedge clock);
      reset <= 1'b1;
      wait_cyc(2);
      reset <= 1'b0;
      chk("mode after reset", {29'h0, mode_active}, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk("max after reset", rd, 32'h3e8);
      apb(1'b0, 8'h1c, 32'h0);
      chk("off-delay after reset", rd, 32'h1e);
      apb(1'b1, 8'h04, 32'h44c);
      half <= 8'h04;
      settle();
      chk("speed over max", {31'h0, speed_out}, 32'h0);
      chk("standstill moving", {31'h0, standstill_out}, 32'h0);
      apb(1'b1, 8'h14, 32'h14);
      settle();
      chk("speed within tolerance", {31'h0, speed_out}, 32'h1);
      apb(1'b1, 8'h18, 32'h5);
      apb(1'b1, 8'h14, 32'h0);
      wait_cyc(20);
      chk("speed held in delay", {31'h0, speed_out}, 32'h1);
      wait_cyc(60);
      chk("speed off after delay", {31'h0, speed_out}, 32'h0);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h00, 32'h8);
      settle();
      chk("fan above minimum", {31'h0, speed_out}, 32'h1);
      half <= 8'h0a;
      settle();
      chk("fan below minimum", {31'h0, speed_out}, 32'h0);
      apb(1'b0, 8'h2c, 32'h0);
      chk("freq at fan speed", rd, 32'h1f4);
      apb(1'b1, 8'h00, 32'h4);
      half <= 8'h00;
      present <= 1'b0;
      settle();
      chk("safe stop standstill", {31'h0, standstill_out}, 32'h0);
      chk("safe stop speed", {31'h0, speed_out}, 32'h0);
      present <= 1'b1;
      settle();
      chk("sensor back standstill", {31'h0, standstill_out}, 32'h1);
      apb(1'b0, 8'h28, 32'h0);
      chk("status word", rd, 32'h93);
      chk("mapped no error", {31'h0, err}, 32'h0);
      apb(1'b0, 8'h2c, 32'h0);
      chk("freq at rest", rd, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      wait_cyc(250);
      chk("old mode kept", {29'h0, mode_active}, 32'h3);
      wait_cyc(100);
      chk("old mode dropped", {29'h0, mode_active}, 32'h2);
      apb(1'b1, 8'h00, 32'h3);
      wait_cyc(250);
      chk("special kept", {29'h0, mode_active}, 32'h6);
      wait_cyc(100);
      chk("agree alone", {29'h0, mode_active}, 32'h4);
      final_report();
   end
endmodule : drive_speed_monitor_bench
